// File: logic/hw_reset_consts.vh
`ifndef HW_RESET_CONSTS_VH
`define HW_RESET_CONSTS_VH
`define CLK_NS 10
`define RST_MIN_NS 20
`define RST_MIN_CYC ((`RST_MIN_NS + `CLK_NS - 1) / `CLK_NS)
`define T_1MS_NS 1000000
`define T_400MS_NS 400000000
`define T_450MS_NS 450000000
`define T_5S_MS 16'h1388
`define T_30S_MS 16'h7530
`define T_31S_MS 16'h7918
`define CYC_1MS (`T_1MS_NS / `CLK_NS)
`define CYC_400MS (`T_400MS_NS / `CLK_NS)
`define CYC_450MS (`T_450MS_NS / `CLK_NS)
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_ERROR 8'h08
`define ADDR_WORD93 8'h0C
`define ADDR_DEVCTL 8'h10
`define ADDR_SIG 8'h14
`define CTRL_RST 32'h0000_0000
`define DIAG_PASS 7'h01
`define SIG_ATA 32'h0000_0101
`define SIG_PKT 32'hEB14_0101
`define ST_BSY 7
`define STAT_BUSY 8'h80
`endif

// File: logic/hw_reset_seq.v
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`include "hw_reset_consts.vh"

module hw_reset_seq #(
    parameter MS_CYC = 100000,                  // cycles in one millisecond
    parameter [31:0] T_400MS = `CYC_400MS,      // dasp deadline, device 1
    parameter [31:0] T_450MS = `CYC_450MS,      // least dasp sampling time
    parameter [31:0] T_1MS = `CYC_1MS           // dev and dasp window
)(
    input wire aclk,                            // 100 MHz clock
    input wire aresetn,                         // sync reset, active low
    input wire reset_pin_n,                     // bus reset, async pin
    input wire dev1_strap,                      // 1: jumper/csel says device 1
    input wire dasp_in_n,                       // dasp pin level, async
    input wire pdiag_in_n,                      // pdiag pin level, async
    input wire selftest_done,                   // local self-test finished
    input wire selftest_pass,                   // local self-test result
    input wire [6:0] diag_code,                 // diagnostic code for error
    input wire srst_req,                        // srst write seen on bus
    input wire devrst_req,                      // device reset cmd seen
    output reg bus_release,                     // 1: float pdiag intrq iordy dmarq dd
    output reg dasp_out_n,                      // dasp output level
    output reg dasp_oe,                         // dasp driven
    output reg pdiag_out_n,                     // pdiag output level
    output reg pdiag_oe,                        // pdiag driven
    output reg selftest_start,                  // one-cycle self-test start
    output reg udma_disable,                    // pulse: drop all udma modes
    output reg mode_restore,                    // pulse: restore saved modes
    output reg soft_reset_go,                   // accepted srst/device reset
    output reg seq_busy,                        // sequence in progress
    input wire [31:0] s_axil_awaddr,            // write address
    input wire s_axil_awvalid,                  // write address valid
    output wire s_axil_awready,                 // write address ready
    input wire [31:0] s_axil_wdata,             // write data
    input wire [3:0] s_axil_wstrb,              // write strobes
    input wire s_axil_wvalid,                   // write data valid
    output wire s_axil_wready,                  // write data ready
    output reg [1:0] s_axil_bresp,              // write response
    output reg s_axil_bvalid,                   // write response valid
    input wire s_axil_bready,                   // write response ready
    input wire [31:0] s_axil_araddr,            // read address
    input wire s_axil_arvalid,                  // read address valid
    output wire s_axil_arready,                 // read address ready
    output reg [31:0] s_axil_rdata,             // read data
    output reg [1:0] s_axil_rresp,              // read response
    output reg s_axil_rvalid,                   // read data valid
    input wire s_axil_rready                    // read data ready
);
    localparam S_IDLE = 3'd0;
    localparam S_IN_RST = 3'd1;
    localparam S_RELEASE = 3'd2;
    localparam S_D0_WAIT = 3'd3;
    localparam S_D0_DASP = 3'd4;
    localparam S_D0_PDIAG = 3'd5;
    localparam S_SET_STAT = 3'd6;
    localparam S_D1_DASP = 3'd7;

    reg [1:0] rst_sync_q;
    reg [1:0] dasp_sync_q;
    reg [1:0] pdiag_sync_q;
    reg [2:0] state_q;
    reg [3:0] rst_len_q;
    reg [31:0] cyc_q;
    reg [17:0] ms_tick_q;
    reg [15:0] ms_q;
    reg is_dev1_q;
    reg err7_q;
    reg [7:0] error_q;
    reg [7:0] status_q;
    reg [15:0] word93_q;
    reg [7:0] devctl_q;
    reg [31:0] sig_q;
    reg dev_bit_q;
    reg pkt_q;
    reg early_stop_q;
    reg dasp_seen_q;
    reg selftest_ok_q;
    reg awdone_q;
    reg wdone_q;
    reg [7:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] s_axil_wstrb_q;

    wire reset_act = ~rst_sync_q[1];
    wire dasp_act = ~dasp_sync_q[1];
    wire pdiag_act = ~pdiag_sync_q[1];
    wire [15:0] t5s = `T_5S_MS;
    wire [15:0] t31s = `T_31S_MS;
    wire [15:0] t30s = `T_30S_MS;

    // two flops on the reset, dasp and pdiag pins before any logic reads them
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rst_sync_q <= 2'h3;
            dasp_sync_q <= 2'h3;
            pdiag_sync_q <= 2'h3;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], reset_pin_n};
            dasp_sync_q <= {dasp_sync_q[0], dasp_in_n};
            pdiag_sync_q <= {pdiag_sync_q[0], pdiag_in_n};
        end
    end

    // ms timebase for the long windows keeps the counter narrow
    always @(posedge aclk)
    begin
        if (!aresetn || state_q == S_IN_RST)
        begin
            cyc_q <= 32'h0;
            ms_tick_q <= 18'h0;
            ms_q <= 16'h0;
        end
        else
        begin
            if (cyc_q != 32'hFFFF_FFFF)
                cyc_q <= cyc_q + 32'h1;
            if (ms_tick_q == MS_CYC[17:0] - 18'h1)
            begin
                ms_tick_q <= 18'h0;
                if (ms_q != 16'hFFFF)
                    ms_q <= ms_q + 16'h1;
            end
            else
                ms_tick_q <= ms_tick_q + 18'h1;
        end
    end

    // reset sequence engine
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q <= S_IDLE;
            rst_len_q <= 4'h0;
            is_dev1_q <= 1'b0;
            err7_q <= 1'b0;
            error_q <= 8'h0;
            status_q <= 8'h0;
            word93_q <= 16'h0;
            sig_q <= `SIG_ATA;
            dev_bit_q <= 1'b0;
            bus_release <= 1'b1;
            dasp_out_n <= 1'b1;
            dasp_oe <= 1'b0;
            pdiag_out_n <= 1'b1;
            pdiag_oe <= 1'b0;
            selftest_start <= 1'b0;
            udma_disable <= 1'b0;
            mode_restore <= 1'b0;
            seq_busy <= 1'b0;
            dasp_seen_q <= 1'b0;
            selftest_ok_q <= 1'b0;
        end
        else
        begin
            selftest_start <= 1'b0;
            udma_disable <= 1'b0;
            mode_restore <= 1'b0;
            rst_len_q <= reset_act ? (rst_len_q == 4'hF ? rst_len_q : rst_len_q + 4'h1)
                                   : 4'h0;
            if (selftest_done)
                selftest_ok_q <= selftest_pass;
            // a valid reset aborts whatever runs, in any state
            if (reset_act && rst_len_q >= `RST_MIN_CYC - 1)
            begin
                state_q <= S_IN_RST;
                bus_release <= 1'b1;
                seq_busy <= 1'b1;
                status_q[`ST_BSY] <= 1'b1;
            end
            else
            case (state_q)
                S_IDLE:
                    ;
                S_IN_RST:
                    if (!reset_act)
                        state_q <= S_RELEASE;
                S_RELEASE:
                begin
                    // pins floated and busy set in the first cycle, well inside 400 ns
                    bus_release <= 1'b1;
                    pdiag_oe <= 1'b0;
                    status_q <= `STAT_BUSY;
                    is_dev1_q <= dev1_strap;
                    udma_disable <= 1'b1;
                    selftest_start <= 1'b1;
                    dasp_seen_q <= 1'b0;
                    selftest_ok_q <= 1'b0;
                    dev_bit_q <= 1'b0;
                    state_q <= dev1_strap ? S_D1_DASP : S_D0_WAIT;
                    dasp_oe <= 1'b0;
                end
                S_D0_WAIT:
                    if (cyc_q >= T_1MS)
                        state_q <= S_D0_DASP;
                S_D0_DASP:
                    if (dasp_act)
                    begin
                        dasp_seen_q <= 1'b1;
                        state_q <= S_D0_PDIAG;
                    end
                    else if (ms_q >= t5s || (early_stop_q && cyc_q >= T_450MS))
                    begin
                        err7_q <= 1'b0;
                        state_q <= S_SET_STAT;
                    end
                S_D0_PDIAG:
                    if (pdiag_act)
                    begin
                        err7_q <= 1'b0;
                        state_q <= S_SET_STAT;
                    end
                    else if (ms_q >= t31s)
                    begin
                        err7_q <= 1'b1;
                        state_q <= S_SET_STAT;
                    end
                S_D1_DASP:
                    if (cyc_q < T_400MS)
                    begin
                        dasp_out_n <= 1'b0;
                        dasp_oe <= 1'b1;
                        state_q <= S_SET_STAT;
                    end
                S_SET_STAT:
                    // a device 1 self-test overrunning 30 s is closed out as failed
                    if (selftest_done || (is_dev1_q && ms_q >= t30s))
                    begin
                        error_q <= is_dev1_q ? {1'b0, diag_code}
                                             : {err7_q, diag_code};
                        sig_q <= pkt_q ? `SIG_PKT : `SIG_ATA;
                        word93_q <= {1'b0, 1'b1, dasp_seen_q, 12'h0, is_dev1_q};
                        if (pkt_q)
                        begin
                            status_q <= status_q & 8'h82;
                            mode_restore <= 1'b1;
                        end
                        else
                            status_q <= status_q & 8'hF2;
                        state_q <= S_IDLE;
                        status_q[`ST_BSY] <= 1'b0;
                        seq_busy <= 1'b0;
                        bus_release <= 1'b0;
                        if (is_dev1_q)
                        begin
                            pdiag_oe <= 1'b1;
                            pdiag_out_n <= ~(selftest_done ? selftest_pass : selftest_ok_q);
                            dasp_oe <= 1'b0;
                            dasp_out_n <= 1'b1;
                        end
                    end
                default:
                    state_q <= S_IDLE;
            endcase
        end
    end

    // srst is cleared at set-status, otherwise holds the last bus write
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            devctl_q <= 8'h0;
            soft_reset_go <= 1'b0;
        end
        else
        begin
            soft_reset_go <= (srst_req || devrst_req) && !seq_busy;
            if (state_q == S_SET_STAT)
                devctl_q[2] <= 1'b0;
            else if (srst_req && !seq_busy)
                devctl_q[2] <= 1'b1;
        end
    end

    // axi4-lite slave: takes aw and w in either order, one of each at a time
    assign s_axil_awready = !awdone_q && !s_axil_bvalid;
    assign s_axil_wready = !wdone_q && !s_axil_bvalid;
    assign s_axil_arready = !s_axil_rvalid;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awdone_q <= 1'b0;
            wdone_q <= 1'b0;
            awaddr_q <= 8'h0;
            wdata_q <= 32'h0;
            s_axil_bvalid <= 1'b0;
            s_axil_bresp <= 2'h0;
            pkt_q <= 1'b0;
            early_stop_q <= 1'b0;
        end
        else
        begin
            if (s_axil_awvalid && s_axil_awready)
            begin
                awdone_q <= 1'b1;
                awaddr_q <= s_axil_awaddr[7:0];
            end
            if (s_axil_wvalid && s_axil_wready)
            begin
                wdone_q <= 1'b1;
                wdata_q <= s_axil_wdata;
            end
            if (awdone_q && wdone_q)
            begin
                awdone_q <= 1'b0;
                wdone_q <= 1'b0;
                s_axil_bvalid <= 1'b1;
                // only the control word is writable; strobes gate its low byte
                if (awaddr_q == `ADDR_CTRL)
                begin
                    s_axil_bresp <= 2'h0;
                    if (s_axil_wstrb_q[0])
                    begin
                        pkt_q <= wdata_q[0];
                        early_stop_q <= wdata_q[1];
                    end
                end
                else
                    s_axil_bresp <= 2'h2;
            end
            else if (s_axil_bvalid && s_axil_bready)
                s_axil_bvalid <= 1'b0;
        end
    end

    // strobes are captured with the data, since the write lands a cycle later
    always @(posedge aclk)
    begin
        if (!aresetn)
            s_axil_wstrb_q <= 4'h0;
        else if (s_axil_wvalid && s_axil_wready)
            s_axil_wstrb_q <= s_axil_wstrb;
    end

    // read mux answers one cycle after the address is taken
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axil_rvalid <= 1'b0;
            s_axil_rdata <= 32'h0;
            s_axil_rresp <= 2'h0;
        end
        else if (s_axil_arvalid && s_axil_arready)
        begin
            s_axil_rvalid <= 1'b1;
            s_axil_rresp <= 2'h0;
            case (s_axil_araddr[7:0])
                `ADDR_CTRL: s_axil_rdata <= {30'h0, early_stop_q, pkt_q};
                `ADDR_STATUS: s_axil_rdata <= {20'h0, dev_bit_q, state_q, status_q};
                `ADDR_ERROR: s_axil_rdata <= {24'h0, error_q};
                `ADDR_WORD93: s_axil_rdata <= {16'h0, word93_q};
                `ADDR_DEVCTL: s_axil_rdata <= {24'h0, devctl_q};
                `ADDR_SIG: s_axil_rdata <= sig_q;
                default:
                begin
                    s_axil_rdata <= 32'h0;
                    s_axil_rresp <= 2'h2;
                end
            endcase
        end
        else if (s_axil_rvalid && s_axil_rready)
            s_axil_rvalid <= 1'b0;
    end
endmodule

// File: verif/hw_reset_seq_sva.sv
module hw_reset_seq_sva #(
    parameter [31:0] T_400MS = 40,
    parameter [31:0] T_450MS = 45,
    parameter [31:0] T_1MS = 10
)(
    input wire aclk, // clock
    input wire aresetn, // sync reset
    input wire reset_pin_n, // bus reset pin
    input wire dev1_strap, // device 1 strap
    input wire dasp_in_n, // dasp wire level
    input wire selftest_pass, // self-test result
    input wire bus_release, // bus floated
    input wire dasp_out_n, // dasp level out
    input wire dasp_oe, // dasp driven
    input wire pdiag_out_n, // pdiag level out
    input wire pdiag_oe, // pdiag driven
    input wire udma_disable, // udma drop pulse
    input wire selftest_start, // self-test kick
    input wire soft_reset_go, // soft reset taken
    input wire seq_busy // sequence running
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] neg_q = 32'h0; // cycles since pin negation
    logic [7:0] low_q = 8'h0; // cycles pin held low
    logic udma_q = 1'b0; // udma drop seen this sequence
    // raw pin timing runs a few cycles ahead of the synced copy, so bounds stay loose
    always @(posedge aclk)
    begin
        neg_q <= !reset_pin_n ? 32'h0 : neg_q + 32'(neg_q != 32'hFFFF_FFFF);
        low_q <= reset_pin_n ? 8'h0 : low_q + 8'(low_q != 8'hFF);
        udma_q <= reset_pin_n && (udma_q || udma_disable);
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_busy_floats: assert property (seq_busy |-> bus_release)
        else $error("bus driven while busy");
    a_busy_on_pulse: assert property ($rose(reset_pin_n) && low_q >= 8'h04 |-> ##[0:40] seq_busy)
        else $error("busy late after reset pulse");
    a_glitch_ignored: assert property ($rose(reset_pin_n) && low_q == 8'h01 && !seq_busy |-> !seq_busy [*6])
        else $error("short pulse started sequence");
    a_soft_held_off: assert property (seq_busy |-> !soft_reset_go)
        else $error("soft reset taken while busy");
    a_dev0_dasp_free: assert property (seq_busy && !dev1_strap && neg_q > T_1MS |-> !dasp_oe)
        else $error("device 0 drives dasp");
    a_dev1_dasp_due: assert property (seq_busy && dev1_strap && neg_q == T_400MS |-> dasp_oe && !dasp_out_n)
        else $error("device 1 dasp late");
    a_dev0_min_wait: assert property ($fell(seq_busy) && !dev1_strap |-> neg_q > T_1MS)
        else $error("device 0 done too early");
    a_dev0_no_dasp: assert property ($fell(seq_busy) && !dev1_strap && dasp_in_n |-> neg_q >= T_450MS)
        else $error("dasp sampling cut short");
    a_udma_dropped: assert property ($fell(seq_busy) |-> udma_q)
        else $error("udma modes not dropped");
    a_test_started: assert property ($rose(udma_disable) |-> selftest_start)
        else $error("self-test not started");
    a_dev1_pdiag_result: assert property ($fell(seq_busy) && dev1_strap |-> pdiag_oe && pdiag_out_n == !selftest_pass)
        else $error("device 1 pdiag wrong");
    c_dev0_done: cover property ($fell(seq_busy) && !dev1_strap && !dasp_in_n);
    c_dev1_pass: cover property ($fell(seq_busy) && dev1_strap && selftest_pass);
    c_glitch: cover property ($rose(reset_pin_n) && low_q == 8'h01);
endmodule

// File: verif/host_model.sv
module host_model (
    input wire logic aclk, // clock
    output logic rst_n, // bus reset pin
    output logic dasp_n, // other device dasp, pulled up when released
    output logic pdiag_n // other device pdiag, pulled up when released
);
    timeunit 1ns;
    timeprecision 1ns;
    int t = 0;
    int dasp_at = -1;
    int pdiag_at = -1;
    initial rst_n = 1'b1;
    // hold reset low for n cycles with the bus idle
    task automatic pulse(input int n);
        rst_n <= 1'b0;
        repeat (n) @(posedge aclk);
        rst_n <= 1'b1;
    endtask
    // the other device asserts its lines at set times after negation
    always @(posedge aclk)
    begin
        t <= rst_n ? t + 1 : 0;
        dasp_n <= !(rst_n && dasp_at >= 0 && t >= dasp_at);
        pdiag_n <= !(rst_n && pdiag_at >= 0 && t >= pdiag_at);
    end
endmodule

// File: verif/device_hw_reset_sequencer_tb.sv
`include "hw_reset_consts.vh"
module device_hw_reset_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MS = 1; // one millisecond shrunk to one cycle
    logic aclk = 1'b0, aresetn = 1'b0, dev1_strap = 1'b0, selftest_done = 1'b0;
    logic selftest_pass = 1'b1, srst_req = 1'b0, devrst_req = 1'b0, mr_seen = 1'b0;
    logic [6:0] diag_code = 7'h01;
    logic [3:0] s_axil_wstrb = 4'hF;
    logic [31:0] s_axil_awaddr = 32'h0, s_axil_wdata = 32'h0, s_axil_araddr = 32'h0;
    logic s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_arvalid = 1'b0;
    logic s_axil_bready = 1'b0, s_axil_rready = 1'b0;
    wire bus_release, dasp_out_n, dasp_oe, pdiag_out_n, pdiag_oe, selftest_start;
    wire udma_disable, mode_restore, soft_reset_go, seq_busy, reset_pin_n;
    wire s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
    wire [1:0] s_axil_bresp, s_axil_rresp;
    wire [31:0] s_axil_rdata;
    wire o_dasp_n, o_pdiag_n;
    int n_errors = 0, samples_checked = 0, st_cnt = 0, cyc = 0, st_at = 20;
    // wired lines: low when either side drives low
    wire dasp_in_n = o_dasp_n & ~(dasp_oe & ~dasp_out_n);
    wire pdiag_in_n = o_pdiag_n & ~(pdiag_oe & ~pdiag_out_n);
    hw_reset_seq #(.MS_CYC(MS), .T_400MS(400 * MS), .T_450MS(450 * MS), .T_1MS(MS)) dut (
        .aclk, .aresetn, .reset_pin_n, .dev1_strap, .dasp_in_n, .pdiag_in_n,
        .selftest_done, .selftest_pass, .diag_code, .srst_req, .devrst_req,
        .bus_release, .dasp_out_n, .dasp_oe, .pdiag_out_n, .pdiag_oe, .selftest_start,
        .udma_disable, .mode_restore, .soft_reset_go, .seq_busy,
        .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready, .s_axil_wdata, .s_axil_wstrb,
        .s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready,
        .s_axil_araddr, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp,
        .s_axil_rvalid, .s_axil_rready);
    host_model host (.aclk, .rst_n(reset_pin_n), .dasp_n(o_dasp_n), .pdiag_n(o_pdiag_n));
    initial
    begin
        forever #5 aclk = ~aclk;
    end
    // self-test ends st_at cycles after negation; cyc cuts a hang short
    always @(posedge aclk)
    begin
        st_cnt <= reset_pin_n ? st_cnt + 1 : 0;
        selftest_done <= reset_pin_n && st_cnt >= st_at;
        mr_seen <= reset_pin_n && (mr_seen || mode_restore);
        cyc <= cyc + 1;
        if (cyc == 75000)
        begin
            n_errors++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        bit aw = 0;
        bit w = 0;
        int k = 0;
        s_axil_awaddr <= a;
        s_axil_wdata <= d;
        s_axil_awvalid <= 1'b1;
        s_axil_wvalid <= 1'b1;
        while (!(aw && w) && k < 50)
        begin
            @(posedge aclk);
            k++;
            aw = aw | s_axil_awready;
            w = w | s_axil_wready;
            s_axil_awvalid <= !aw;
            s_axil_wvalid <= !w;
        end
        s_axil_bready <= 1'b1;
        do @(posedge aclk); while (s_axil_bvalid !== 1'b1 && ++k < 100);
        s_axil_bready <= 1'b0;
        chk("bresp", 32'(er), 32'(s_axil_bresp));
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        int k = 0;
        s_axil_araddr <= a;
        s_axil_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axil_arready !== 1'b1 && ++k < 50);
        s_axil_arvalid <= 1'b0;
        s_axil_rready <= 1'b1;
        do @(posedge aclk); while (s_axil_rvalid !== 1'b1 && ++k < 100);
        s_axil_rready <= 1'b0;
        d = s_axil_rdata;
        r = s_axil_rresp;
    endtask
    task automatic run_seq(input logic s, input logic [31:0] ctl, input int da, input int pa,
        input int again, input int lo, input int hi, input logic e7, input logic [31:0] w93);
        logic [31:0] d;
        logic [1:0] r;
        int k = 0;
        dev1_strap <= s;
        wr(`ADDR_CTRL, ctl, 2'b00);
        host.pulse(4);
        if (again > 0)
        begin
            repeat (again) @(posedge aclk);
            host.pulse(4);
        end
        host.dasp_at <= da;
        host.pdiag_at <= pa;
        repeat (2 * MS + 4) @(posedge aclk);
        rd(`ADDR_STATUS, d, r);
        chk("busy set", 32'h1, 32'(d[`ST_BSY]));
        wr(`ADDR_DEVCTL, 32'h0000_0004, 2'b10);
        srst_req <= 1'b1;
        devrst_req <= 1'b1;
        @(posedge aclk);
        srst_req <= 1'b0;
        devrst_req <= 1'b0;
        do @(posedge aclk); while (seq_busy !== 1'b0 && ++k < 40000);
        chk("done time", 32'h1, 32'(st_cnt >= lo && st_cnt <= hi));
        rd(`ADDR_ERROR, d, r);
        chk("diag code", 32'(diag_code), 32'(d[6:0]));
        if (!s)
            chk("error bit7", 32'(e7), 32'(d[7]));
        rd(`ADDR_SIG, d, r);
        chk("signature", ctl[0] ? `SIG_PKT : `SIG_ATA, d);
        rd(`ADDR_DEVCTL, d, r);
        chk("srst bit", 32'h0, 32'(d[2]));
        rd(`ADDR_STATUS, d, r);
        chk("status", 32'h0, d & (ctl[0] ? 32'h0000_087D : 32'h0000_088D));
        rd(`ADDR_WORD93, d, r);
        chk("word93", w93, d & (s ? 32'h0000_DFFF : 32'h0000_FFFF));
        if (ctl[0])
            chk("mode restore", 32'h1, 32'(mr_seen));
        srst_req <= 1'b1;
        @(posedge aclk);
        srst_req <= 1'b0;
        @(posedge aclk);
        chk("soft reset go", 32'h1, 32'(soft_reset_go));
    endtask
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        rd(`ADDR_CTRL, d, r);
        chk("ctrl reset", 32'h0, d);
        s_axil_wstrb <= 4'h0;
        wr(`ADDR_CTRL, 32'h0000_0003, 2'b00);
        s_axil_wstrb <= 4'hF;
        rd(`ADDR_CTRL, d, r);
        chk("ctrl strobed off", 32'h0, d);
        rd(32'h0000_0040, d, r);
        chk("unmapped read", 32'h2, 32'(r));
        wr(`ADDR_STATUS, 32'h0, 2'b10);
    endtask
    task automatic t_glitch();
        host.pulse(1);
        repeat (6) @(posedge aclk);
        chk("glitch busy", 32'h0, 32'(seq_busy));
    endtask
    task automatic t_dev1(input logic pass, input int at, input int lo);
        selftest_pass <= pass;
        diag_code <= pass ? 7'h01 : 7'h05;
        st_at <= at;
        run_seq(1'b1, 32'h0, -1, -1, 0, lo, lo + 15, 1'b0, 32'h0000_4001);
        chk("pdiag drive", 32'h1, 32'(pdiag_oe));
        chk("pdiag level", 32'(!pass), 32'(pdiag_out_n));
    endtask
    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_glitch();
        run_seq(1'b0, 32'h0, -1, -1, 100, 5000, 5015, 1'b0, 32'h0000_4000);
        run_seq(1'b0, 32'h2, -1, -1, 0, 450, 465, 1'b0, 32'h0000_4000);
        run_seq(1'b0, 32'h0, 30, 60, 0, 60, 75, 1'b0, 32'h0000_6000);
        diag_code <= 7'h02;
        run_seq(1'b0, 32'h1, 30, -1, 0, 31000, 31015, 1'b1, 32'h0000_6000);
        t_dev1(1'b1, 20, 20);
        t_dev1(1'b0, 20, 20);
        t_dev1(1'b0, 100000, 30000);
        tally_and_finish();
    end
endmodule
bind hw_reset_seq hw_reset_seq_sva #(.T_400MS(T_400MS), .T_450MS(T_450MS), .T_1MS(T_1MS)) u_sva (
    .aclk, .aresetn, .reset_pin_n, .dev1_strap, .dasp_in_n, .selftest_pass, .bus_release,
    .dasp_out_n, .dasp_oe, .pdiag_out_n, .pdiag_oe, .udma_disable, .selftest_start,
    .soft_reset_go, .seq_busy);
